/* verilog/dsf_params.svh */
// constants for the special function command decoder
`ifndef DSF_PARAMS_SVH
`define DSF_PARAMS_SVH
`define DSF_SEL_SFR       2'h0
`define DSF_CODE_PD       5'h08
`define DSF_CODE_PU       5'h09
`define DSF_CODE_MON      5'h0A
`define DSF_CODE_CTRL     5'h0C
`define DSF_CODE_RST      5'h0F
`define DSF_B_PDHIZ       13
`define DSF_B_REFLVL      12
`define DSF_B_BOOST       11
`define DSF_B_REFSRC      10
`define DSF_B_MONEN       9
`define DSF_B_THERM       8
`define DSF_B_TGL0        2
`define DSF_MON_LO        8
`define DSF_CTRL_MASK     14'h3F3C
`define DSF_CTRL_RESET    14'h2000
`define DSF_MON_TRISTATE  6'h3F
`define DSF_MON_LAST_IN   6'h23
`define DSF_CLK_KHZ       20000
`define DSF_WAKE_US       8
`define DSF_RST_US        135
`endif

/* verilog/dsf_pkg.sv */
// types for the special function command decoder
package dsf_pkg;
  typedef enum logic [1:0] {
    DSF_IDLE  = 2'b00,
    DSF_WAKE  = 2'b01,
    DSF_RESET = 2'b10
  } dsf_mode_e;

  typedef struct packed {
    logic        valid;
    logic [1:0]  reg_sel;
    logic        rw;
    logic        ab;
    logic [4:0]  addr;
    logic [13:0] data;
  } dsf_cmd_s;

  typedef struct packed {
    dsf_mode_e   mode;
    logic [11:0] timer;
    logic        sw_pd;
    logic        therm_trip;
    logic [13:0] ctrl;
    logic [5:0]  mon_sel;
    logic [3:0]  ab_state;
    logic        rd_valid;
    logic [13:0] rd_data;
    logic        dw_valid;
    logic [4:0]  dw_chan;
    logic        dw_use_b;
    logic        clr_out;
  } dsf_state_s;
endpackage

/* verilog/dsf_cmd.sv */
// special function command decoder of a 32-channel output converter
`include "dsf_params.svh"

module dsf_cmd #(
  parameter logic REF_LEVEL_DEFAULT = 1'b1, // reset value of bit 12
  parameter int   TIMER_W           = 12    // settle/busy counter width
) (
  input  wire logic              ref_clk,        // 20 MHz clock
  input  wire logic              reset_n,        // async reset
  input  wire dsf_pkg::dsf_cmd_s cmd,            // decoded command word
  input  wire logic              hw_pd_req,      // hardware power-down
  input  wire logic              die_overtemp,   // die above 130 C
  input  wire logic              output_load_strobe, // load pulse
  output logic                   busy,           // soft reset running
  output logic                   powered_down,   // effective power-down
  output logic                   amp_ready,      // amplifiers settled
  output logic                   pd_output_hiz,  // pd state: hi-z
  output logic                   ref_level_high, // 2.5 V reference
  output logic                   amp_boost_en,   // amplifier boost
  output logic                   int_ref_en,     // internal reference
  output logic [3:0]             toggle_en,      // toggle per group
  output logic [3:0]             group_use_b,    // group shows B
  output logic [5:0]             monitor_sel,    // monitor address
  output logic                   monitor_oe,     // monitor driven
  output logic                   rd_valid,       // read answer pulse
  output logic [13:0]            rd_data,        // read answer data
  output logic                   dw_valid,       // data write pulse
  output logic [4:0]             dw_chan,        // data write channel
  output logic                   dw_use_b,       // data write to B
  output logic                   clear_channels  // clear outputs pulse
);
  import dsf_pkg::*;

  localparam int WAKE_CYC = `DSF_WAKE_US * `DSF_CLK_KHZ / 1000;
  localparam int RST_CYC  = `DSF_RST_US * `DSF_CLK_KHZ / 1000;

  initial
  begin
    if (WAKE_CYC < 1 || RST_CYC < 1 || RST_CYC >= (1 << TIMER_W))
      $error("timer width cannot hold the settle counts");
  end

  function automatic logic is_sfr(input dsf_cmd_s c,
                                  input logic [4:0] code);
    is_sfr = c.valid && c.reg_sel == `DSF_SEL_SFR && c.addr == code;
  endfunction

  function automatic logic mon_drives(input logic [5:0] sel);
    mon_drives = sel <= `DSF_MON_LAST_IN;
  endfunction

  dsf_state_s st_reg;
  dsf_state_s st_next;
  logic       pd_eff;
  logic       not_busy;
  logic       wr_ok;
  logic       cmd_pd;
  logic       cmd_pu;
  logic       cmd_rst;
  logic       cmd_mon;
  logic       cmd_cw;
  logic       cmd_cr;
  logic       cmd_dw;
  logic [3:0] ab_flip;

  assign pd_eff   = hw_pd_req | st_reg.sw_pd | st_reg.therm_trip;
  assign not_busy = st_reg.mode != DSF_RESET;
  // writes of any register but power-down and power-up are refused while powered down
  assign wr_ok    = not_busy && !pd_eff;

  assign cmd_pd  = is_sfr(cmd, `DSF_CODE_PD) && !cmd.rw && not_busy;
  assign cmd_pu  = is_sfr(cmd, `DSF_CODE_PU) && !cmd.rw && not_busy;
  assign cmd_rst = is_sfr(cmd, `DSF_CODE_RST) && !cmd.rw && wr_ok;
  assign cmd_mon = is_sfr(cmd, `DSF_CODE_MON) && !cmd.rw && wr_ok;
  assign cmd_cw  = is_sfr(cmd, `DSF_CODE_CTRL) && !cmd.rw && wr_ok;
  assign cmd_cr  = is_sfr(cmd, `DSF_CODE_CTRL) && cmd.rw && not_busy;
  assign cmd_dw  = cmd.valid && cmd.reg_sel != `DSF_SEL_SFR && !cmd.rw
                   && wr_ok;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_tgl
      // load strobe flips only groups with toggle enabled
      assign ab_flip[g] = output_load_strobe
                          && st_reg.ctrl[`DSF_B_TGL0 + g];
    end
  endgenerate

  always_comb
  begin
    st_next          = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.dw_valid = 1'b0;
    st_next.clr_out  = 1'b0;
    st_next.ab_state = st_reg.ab_state ^ ab_flip;

    unique case (st_reg.mode)
      DSF_IDLE:
        st_next.timer = '0;
      DSF_WAKE:
      begin
        if (st_reg.timer == '0)
          st_next.mode = DSF_IDLE;
        else
          st_next.timer = st_reg.timer - 1'b1;
        if (pd_eff)
          st_next.mode = DSF_IDLE;
      end
      DSF_RESET:
      begin
        if (st_reg.timer == '0)
          st_next.mode = DSF_IDLE;
        else
          st_next.timer = st_reg.timer - 1'b1;
      end
      default:
        st_next.mode = DSF_IDLE;
    endcase

    if (cmd_pd)
      st_next.sw_pd = 1'b1;
    if (cmd_pu)
    begin
      st_next.sw_pd = 1'b0;
      // amplifiers only come back once the die is cool again
      if (!die_overtemp)
        st_next.therm_trip = 1'b0;
      if (!hw_pd_req && (die_overtemp ? !st_reg.therm_trip
                                      : 1'b1) && pd_eff)
      begin
        st_next.mode  = DSF_WAKE;
        st_next.timer = TIMER_W'(WAKE_CYC - 1);
      end
    end
    // a fresh overtemperature wins over a clearing power-up
    if (st_reg.ctrl[`DSF_B_THERM] && die_overtemp)
      st_next.therm_trip = 1'b1;

    if (cmd_cw)
      st_next.ctrl = cmd.data & `DSF_CTRL_MASK;
    if (cmd_cr)
    begin
      st_next.rd_valid = 1'b1;
      st_next.rd_data  = st_reg.ctrl & `DSF_CTRL_MASK;
    end
    if (cmd_mon)
      st_next.mon_sel = cmd.data[13:`DSF_MON_LO];
    if (cmd_dw)
    begin
      st_next.dw_valid = 1'b1;
      st_next.dw_chan  = cmd.addr;
      st_next.dw_use_b = cmd.ab
                         && st_reg.ctrl[`DSF_B_TGL0 + cmd.addr[4:3]];
    end
    if (cmd_rst)
    begin
      st_next.ctrl = `DSF_CTRL_RESET;
      st_next.ctrl[`DSF_B_REFLVL] = REF_LEVEL_DEFAULT;
      st_next.mon_sel  = `DSF_MON_TRISTATE;
      st_next.ab_state = '0;
      st_next.clr_out  = 1'b1;
      st_next.mode     = DSF_RESET;
      st_next.timer    = TIMER_W'(RST_CYC - 1);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg          <= '0;
      st_reg.mode     <= DSF_IDLE;
      st_reg.ctrl     <= `DSF_CTRL_RESET;
      st_reg.ctrl[`DSF_B_REFLVL] <= REF_LEVEL_DEFAULT;
      st_reg.mon_sel  <= `DSF_MON_TRISTATE;
    end
    else
      st_reg <= st_next;
  end

  assign busy           = st_reg.mode == DSF_RESET;
  assign powered_down   = pd_eff;
  assign amp_ready      = !pd_eff && st_reg.mode == DSF_IDLE;
  assign pd_output_hiz  = st_reg.ctrl[`DSF_B_PDHIZ];
  assign ref_level_high = st_reg.ctrl[`DSF_B_REFLVL];
  assign amp_boost_en   = st_reg.ctrl[`DSF_B_BOOST];
  assign int_ref_en     = st_reg.ctrl[`DSF_B_REFSRC];
  assign toggle_en      = st_reg.ctrl[`DSF_B_TGL0 +: 4];
  assign group_use_b    = st_reg.ab_state;
  assign monitor_sel    = st_reg.mon_sel;
  // undefined addresses and 63 leave the pin undriven
  assign monitor_oe     = st_reg.ctrl[`DSF_B_MONEN]
                          && mon_drives(st_reg.mon_sel);
  assign rd_valid       = st_reg.rd_valid;
  assign rd_data        = st_reg.rd_data;
  assign dw_valid       = st_reg.dw_valid;
  assign dw_chan        = st_reg.dw_chan;
  assign dw_use_b       = st_reg.dw_use_b;
  assign clear_channels = st_reg.clr_out;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  pd_entry_a: assert property (cmd_pd |=> powered_down)
    else $error("soft power-down not taken");
  pd_hold_a: assert property (pd_eff && is_sfr(cmd, `DSF_CODE_CTRL)
      && !cmd.rw |=> $stable(st_reg.ctrl))
    else $error("control written while powered down");
  mon_hold_a: assert property (pd_eff |=> $stable(monitor_sel))
    else $error("monitor address changed while powered down");
  wake_time_a: assert property (cmd_pu && pd_eff && !hw_pd_req
      && !st_reg.therm_trip |=> (!amp_ready)[*8])
    else $error("amplifiers ready before settle time");
  rst_start_a: assert property (cmd_rst |=> busy && clear_channels
      && st_reg.timer == TIMER_W'(RST_CYC - 1))
    else $error("soft reset did not start busy period");
  rst_end_a: assert property (busy && st_reg.timer == '0
      |=> !busy)
    else $error("busy period did not end");
  ctrl_wr_a: assert property (cmd_cw |=> st_reg.ctrl ==
      ($past(cmd.data) & `DSF_CTRL_MASK))
    else $error("control write not stored");
  ctrl_rd_a: assert property (cmd_cr |=> rd_valid
      && rd_data == $past(st_reg.ctrl)
      && (rd_data & ~`DSF_CTRL_MASK) == '0)
    else $error("control read wrong");
  therm_trip_a: assert property (st_reg.ctrl[`DSF_B_THERM]
      && die_overtemp |=> powered_down [*2])
    else $error("thermal guard did not power down");
  therm_pu_a: assert property (st_reg.therm_trip && die_overtemp
      && cmd_pu |=> powered_down)
    else $error("power-up while die still hot");
  mon_oe_a: assert property (monitor_oe |-> st_reg.ctrl[`DSF_B_MONEN]
      && monitor_sel <= `DSF_MON_LAST_IN)
    else $error("monitor driven on bad address");
  toggle_a: assert property (output_load_strobe && !cmd_rst
      && toggle_en[3] |=> group_use_b[3] != $past(group_use_b[3]))
    else $error("toggle group did not flip");

  // each stored control bit must follow the written data word
  pdhiz_bit_a: assert property (cmd_cw
      |=> pd_output_hiz == $past(cmd.data[`DSF_B_PDHIZ]))
    else $error("power-down output state bit not stored");

  ref_level_a: assert property (cmd_cw
      |=> ref_level_high == $past(cmd.data[`DSF_B_REFLVL]))
    else $error("reference level bit not stored");

  boost_bit_a: assert property (cmd_cw
      |=> amp_boost_en == $past(cmd.data[`DSF_B_BOOST]))
    else $error("boost bit not stored");

  ref_src_a: assert property (cmd_cw
      |=> int_ref_en == $past(cmd.data[`DSF_B_REFSRC]))
    else $error("reference source bit not stored");

  mon_off_a: assert property (!st_reg.ctrl[`DSF_B_MONEN]
      |-> !monitor_oe)
    else $error("monitor driven while disabled");

  therm_bit_a: assert property (cmd_cw
      |=> st_reg.ctrl[`DSF_B_THERM] == $past(cmd.data[`DSF_B_THERM]))
    else $error("thermal guard bit not stored");

  ctrl_unused_a: assert property (
      (st_reg.ctrl & ~`DSF_CTRL_MASK) == '0)
    else $error("unused control bit set");

  toggle_map_a: assert property (cmd_cw
      |=> toggle_en == $past(cmd.data[`DSF_B_TGL0 +: 4]))
    else $error("toggle group bits not stored");

  mon_addr_a: assert property (cmd_mon
      |=> monitor_sel == 6'($past(cmd.data) >> `DSF_MON_LO))
    else $error("monitor address not taken from upper data");

  mon_undef_a: assert property (monitor_sel > `DSF_MON_LAST_IN
      |-> !monitor_oe)
    else $error("monitor driven on undefined address");

  sel_ab_a: assert property (cmd_dw && !cmd.ab
      |=> dw_valid && !dw_use_b)
    else $error("data write sent to B register without request");

  dw_chan_a: assert property (cmd_dw
      |=> dw_valid && dw_chan == $past(cmd.addr))
    else $error("data write channel wrong");

  pd_refuse_a: assert property (pd_eff && cmd.valid
      && cmd.reg_sel != `DSF_SEL_SFR |=> !dw_valid)
    else $error("data write taken while powered down");

  rst_refuse_a: assert property (pd_eff
      && is_sfr(cmd, `DSF_CODE_RST) |=> !clear_channels)
    else $error("soft reset taken while powered down");

  hw_pd_a: assert property (hw_pd_req
      |-> powered_down && !amp_ready)
    else $error("hardware power-down request ignored");

  pu_clear_a: assert property (cmd_pu
      |=> !st_reg.sw_pd)
    else $error("soft power-up did not clear soft power-down");

  rst_regs_a: assert property (cmd_rst
      |=> monitor_sel == `DSF_MON_TRISTATE && group_use_b == '0
      && !amp_boost_en && !int_ref_en)
    else $error("soft reset did not restore defaults");

  busy_refuse_a: assert property (busy
      && is_sfr(cmd, `DSF_CODE_CTRL) && !cmd.rw |=> $stable(st_reg.ctrl))
    else $error("control written during soft reset");

  clr_pulse_a: assert property (clear_channels
      |=> !clear_channels)
    else $error("clear pulse longer than one cycle");
endmodule // dsf_cmd

/* verification/dsf_host.sv */
// host controller model that issues command words to the decoder
module dsf_host (
  input  wire logic        ref_clk, // command clock
  output dsf_pkg::dsf_cmd_s cmd     // command word to decoder
);
  timeunit 1ns;
  timeprecision 1ps;
  import dsf_pkg::*;

  initial cmd = '0;

  // one word per call, held for exactly one taking edge
  task automatic send(input logic [1:0] sel, input logic rw,
                      input logic ab, input logic [4:0] addr,
                      input logic [13:0] data);
    @(posedge ref_clk);
    #1;
    cmd <= '{1'b1, sel, rw, ab, addr, data};
    @(posedge ref_clk);
    #1;
    // released fields flip so a stale word is never mistaken for a new one
    cmd <= '{1'b0, ~sel, ~rw, ~ab, ~addr, ~data};
  endtask
endmodule // dsf_host

/* verification/dsf_cmd_tb.sv */
// self-checking bench for the special function command decoder
`include "dsf_params.svh"
module dsf_cmd_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dsf_pkg::*;

  logic        ref_clk = 1'b0, reset_n = 1'b0, hw_pd_req = 1'b0;
  logic        die_overtemp = 1'b0, output_load_strobe = 1'b0;
  dsf_cmd_s    cmd;
  logic        busy, powered_down, amp_ready, pd_output_hiz;
  logic        ref_level_high, amp_boost_en, int_ref_en, monitor_oe;
  logic        rd_valid, dw_valid, dw_use_b, clear_channels;
  logic [3:0]  toggle_en, group_use_b;
  logic [5:0]  monitor_sel;
  logic [13:0] rd_data;
  logic [4:0]  dw_chan;
  int          bad_count = 0, comparisons = 0, cycles = 0;
  logic [13:0] rows [4][2] = '{'{14'h3FFF, 14'h3F3C},
    '{14'h00C3, 14'h0000}, '{14'h2A14, 14'h2A14}, '{14'h1528, 14'h1528}};
  logic [5:0]  mons [7] = '{6'h00, 6'h1F, 6'h20, 6'h23, 6'h24, 6'h3E,
                            6'h3F};

  dsf_host host (.ref_clk, .cmd);
  dsf_cmd dut (.ref_clk, .reset_n, .cmd, .hw_pd_req, .die_overtemp,
    .output_load_strobe, .busy, .powered_down, .amp_ready, .pd_output_hiz,
    .ref_level_high, .amp_boost_en, .int_ref_en, .toggle_en, .group_use_b,
    .monitor_sel, .monitor_oe, .rd_valid, .rd_data, .dw_valid, .dw_chan,
    .dw_use_b, .clear_channels);

  always #25 ref_clk = ~ref_clk;

  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard: whole run needs about 2930 cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic sfr(input logic rw, input logic [4:0] a,
                     input logic [13:0] d);
    host.send(`DSF_SEL_SFR, rw, 1'b0, a, d);
  endtask

  // control bits 9 and 8 only show through monitor and thermal paths
  task automatic chk_ctrl(input logic [13:0] e);
    check({pd_output_hiz, ref_level_high, amp_boost_en, int_ref_en, 6'h00,
           toggle_en}, {e[13:10], 6'h00, e[5:2]});
  endtask

  task automatic chk_read(input logic [13:0] e);
    sfr(1'b1, `DSF_CODE_CTRL, 14'h0000);
    check(rd_valid, 1'b1);
    check(rd_data, e);
  endtask

  initial
  begin
    repeat (5) @(posedge ref_clk);
    check({busy, powered_down, amp_ready, monitor_oe}, 4'h2);
    check(monitor_sel, `DSF_MON_TRISTATE);
    #1 reset_n <= 1'b1;
    chk_ctrl(14'h3000);
    chk_read(14'h3000);
    for (int i = 0; i < 4; i++)
    begin
      sfr(1'b0, `DSF_CODE_CTRL, rows[i][0]);
      chk_ctrl(rows[i][1]);
      chk_read(rows[i][1]);
    end
    sfr(1'b0, `DSF_CODE_CTRL, 14'h0200);
    for (int i = 0; i < 7; i++)
    begin
      sfr(1'b0, `DSF_CODE_MON, {mons[i], 8'hA5});
      check(monitor_sel, mons[i]);
      check(monitor_oe, mons[i] <= 6'h23);
    end
    sfr(1'b0, `DSF_CODE_MON, 14'h0500);
    sfr(1'b0, `DSF_CODE_CTRL, 14'h0008);
    check(monitor_oe, 1'b0);
    host.send(2'h3, 1'b0, 1'b1, 5'd9, 14'h1234);
    check({dw_valid, dw_use_b, dw_chan}, {2'b11, 5'd9});
    host.send(2'h3, 1'b0, 1'b1, 5'd0, 14'h1234);
    check({dw_valid, dw_use_b, dw_chan}, {2'b10, 5'd0});
    output_load_strobe <= 1'b1;
    @(posedge ref_clk);
    #1 output_load_strobe <= 1'b0;
    check(group_use_b, 4'h2);
    sfr(1'b0, `DSF_CODE_CTRL, 14'h003C);
    output_load_strobe <= 1'b1;
    @(posedge ref_clk);
    #1 output_load_strobe <= 1'b0;
    check(group_use_b, 4'hD);
    sfr(1'b0, `DSF_CODE_PD, 14'h3FFF);
    check({powered_down, amp_ready}, 2'b10);
    sfr(1'b0, `DSF_CODE_CTRL, 14'h3FFF);
    chk_ctrl(14'h003C);
    chk_read(14'h003C);
    host.send(2'h3, 1'b0, 1'b0, 5'd3, 14'h0001);
    check(dw_valid, 1'b0);
    sfr(1'b0, `DSF_CODE_PU, 14'h0000);
    check({powered_down, amp_ready}, 2'b00);
    repeat (159) @(posedge ref_clk);
    #1 check(amp_ready, 1'b0);
    @(posedge ref_clk);
    #1 check(amp_ready, 1'b1);
    hw_pd_req <= 1'b1;
    @(posedge ref_clk);
    #1 check(powered_down, 1'b1);
    sfr(1'b0, `DSF_CODE_PU, 14'h0000);
    check(powered_down, 1'b1);
    hw_pd_req <= 1'b0;
    @(posedge ref_clk);
    #1 check(powered_down, 1'b0);
    sfr(1'b0, `DSF_CODE_CTRL, 14'h013C);
    die_overtemp <= 1'b1;
    @(posedge ref_clk);
    #1 check(powered_down, 1'b1);
    sfr(1'b0, `DSF_CODE_PU, 14'h0000);
    check(powered_down, 1'b1);
    die_overtemp <= 1'b0;
    sfr(1'b0, `DSF_CODE_PU, 14'h0000);
    check(powered_down, 1'b0);
    sfr(1'b0, `DSF_CODE_RST, 14'h0000);
    check({busy, clear_channels, group_use_b}, 6'h30);
    check(monitor_sel, `DSF_MON_TRISTATE);
    chk_ctrl(14'h3000);
    sfr(1'b0, `DSF_CODE_CTRL, 14'h3FFF);
    chk_ctrl(14'h3000);
    repeat (2697) @(posedge ref_clk);
    #1 check(busy, 1'b1);
    @(posedge ref_clk);
    #1 check(busy, 1'b0);
    end_of_test();
  end
endmodule // dsf_cmd_tb
